// ==== logic/gpib_host_pkg.sv ====
// Constants, register map and types of the GPIB transceiver steering host
package gpib_host_pkg;

    // Register port
    localparam int          ADDR_W        = 4;
    localparam int          DATA_W        = 32;
    localparam logic [3:0]  ADDR_MODE     = 4'h0;
    localparam logic [3:0]  ADDR_DRIVE    = 4'h4;
    localparam logic [3:0]  ADDR_CMD      = 4'h8;
    localparam logic [3:0]  ADDR_STATUS   = 4'hC;

    // Terminal-side management channels, one bit each
    localparam int          NUM_CH        = 5;
    localparam int          CH_ATN        = 0;
    localparam int          CH_EOI        = 1;
    localparam int          CH_SRQ        = 2;
    localparam int          CH_REN        = 3;
    localparam int          CH_IFC        = 4;
    localparam logic [4:0]  LINE_IDLE     = 5'h1F;

    // Mode register fields
    localparam int          MODE_IFS_LSB  = 0;
    localparam int          MODE_IFS_W    = 3;
    localparam int          MODE_CTL_LSB  = 3;
    localparam int          MODE_CTL_W    = 2;
    localparam int          MODE_SYS_BIT  = 5;
    localparam int          MODE_PU_LSB   = 6;
    localparam int          MODE_PU_W     = 2;

    // Drive register fields
    localparam int          DRV_ATN_BIT   = 0;
    localparam int          DRV_EOI_BIT   = 1;
    localparam int          DRV_SRQ_BIT   = 2;

    // Command register fields
    localparam int          CMD_REN_GO    = 0;
    localparam int          CMD_REN_VAL   = 1;
    localparam int          CMD_IFC_GO    = 2;
    localparam int          CMD_IFC_VAL   = 3;

    // Status register fields
    localparam int          ST_LINES_LSB  = 0;
    localparam int          ST_TALK_BIT   = 5;
    localparam int          ST_ACF_BIT    = 6;
    localparam int          ST_PU_BIT     = 7;
    localparam int          ST_REF_BIT    = 8;

    // Interface function state that decides the data-line talker
    typedef enum logic [2:0] {
        IFS_IDLE,
        IFS_TALK,
        IFS_CTL_XFER,
        IFS_SPOLL,
        IFS_PPOLL,
        IFS_LISTEN
    } ifs_e;

    // Controller function state
    typedef enum logic [1:0] {
        CTL_IDLE,
        CTL_ADDRESSED,
        CTL_ACTIVE,
        CTL_STANDBY
    } ctl_e;

    // Data-line drive choice
    typedef enum logic [1:0] {
        PU_AUTO,
        PU_OPEN,
        PU_TOTEM
    } pu_e;

endpackage : gpib_host_pkg

// ==== logic/steer_if.sv ====
// Steering controls and resulting channel directions between host modules
`timescale 1ns/1ps
interface steer_if;
    logic       steer;
    logic       talk;
    logic       sysctl;
    logic       atn;
    logic [4:0] tx;

    modport host (output steer, output talk, output sysctl, output atn,
                  input tx);
    modport map  (input steer, input talk, input sysctl, input atn,
                  output tx);
endinterface : steer_if

// ==== logic/steer_map.sv ====
// Mirror of the transceiver direction decode, seen from the host
`timescale 1ns/1ps
module steer_map
    import gpib_host_pkg::*;
(
    // Steering in, directions out
    steer_if.map sif
);

    logic [NUM_CH-1:0] tx_v;

    // EOI follows ATN only while steer and talk controls agree
    always_comb begin
        tx_v         = '0;
        tx_v[CH_ATN] = ~sif.steer;
        tx_v[CH_SRQ] = sif.steer;
        tx_v[CH_REN] = sif.sysctl;
        tx_v[CH_IFC] = sif.sysctl;
        if (sif.steer == sif.talk) begin
            tx_v[CH_EOI] = sif.atn ? sif.talk : ~sif.steer;
        end else begin
            tx_v[CH_EOI] = sif.talk;
        end
    end

    // Bit set means the transceiver carries host toward the bus
    assign sif.tx = tx_v;

endmodule : steer_map

// ==== logic/gpib_host.sv ====
// Host that steers a five-channel GPIB management transceiver
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module gpib_host
    import gpib_host_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,

    // Register port
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                wr_stb,
    input  wire logic                rd_stb,
    output logic      [DATA_W-1:0]   rd_data,

    // Transceiver control pins
    output logic                     talk_enable,
    output logic                     active_ctl_flag,
    output logic                     system_ctl_select,
    output logic                     pull_up_select,

    // Terminal-side management lines, two-way
    input  wire logic [NUM_CH-1:0]   line_in,
    output logic      [NUM_CH-1:0]   line_out,
    output logic      [NUM_CH-1:0]   line_oe_n
);

    typedef struct packed {
        logic [MODE_IFS_W-1:0] ifs;
        logic [MODE_CTL_W-1:0] ctl;
        logic                  sysctl;
        logic [MODE_PU_W-1:0]  pu_mode;
        logic [NUM_CH-1:0]     line_val;
        logic [NUM_CH-1:0]     line_oe_n;
        logic [NUM_CH-1:0]     sync1;
        logic [NUM_CH-1:0]     sync2;
        logic                  talk;
        logic                  acf;
        logic                  pus;
        logic                  refused;
        logic [DATA_W-1:0]     rd_data;
    } state_s;

    localparam state_s STATE_RST = '{
        ifs:       IFS_IDLE,
        ctl:       CTL_IDLE,
        sysctl:    1'b0,
        pu_mode:   PU_AUTO,
        line_val:  LINE_IDLE,
        line_oe_n: LINE_IDLE,
        sync1:     LINE_IDLE,
        sync2:     LINE_IDLE,
        talk:      1'b0,
        acf:       1'b1,
        pus:       1'b1,
        refused:   1'b0,
        rd_data:   '0
    };

    state_s   state_ff;
    state_s   nxt_state;
    steer_if  sif ();
    logic     atn_lvl;
    logic     eoi_lvl;
    logic     nxt_talk;
    logic     nxt_acf;
    logic     nxt_sysctl;
    logic     nxt_atn_val;

    // Steering decode mirrors the transceiver so the host fights it only on EOI, while the synchronised ATN still trails a bus change
    steer_map u_steer_map (
        .sif (sif)
    );

    // ATN as it will stand after this edge: the next own drive while the
    // host transmits it, else the synchronised bus level, which trails
    assign atn_lvl = nxt_acf ? state_ff.sync2[CH_ATN] : nxt_atn_val;
    // EOI as it stands now, only for the pull-up choice
    assign eoi_lvl = state_ff.line_oe_n[CH_EOI] ? state_ff.sync2[CH_EOI]
                                                : state_ff.line_val[CH_EOI];

    // Next control levels, decoded from the next mode fields
    always_comb begin
        logic [MODE_IFS_W-1:0] ifs_v;
        logic [MODE_CTL_W-1:0] ctl_v;
        ifs_v       = state_ff.ifs;
        ctl_v       = state_ff.ctl;
        nxt_sysctl  = state_ff.sysctl;
        nxt_atn_val = state_ff.line_val[CH_ATN];
        if (wr_stb && addr == ADDR_MODE) begin
            ifs_v      = wr_data[MODE_IFS_LSB +: MODE_IFS_W];
            ctl_v      = wr_data[MODE_CTL_LSB +: MODE_CTL_W];
            nxt_sysctl = wr_data[MODE_SYS_BIT];
        end
        if (wr_stb && addr == ADDR_DRIVE) begin
            nxt_atn_val = wr_data[DRV_ATN_BIT];
        end
        case (ifs_e'(ifs_v))
            IFS_TALK, IFS_CTL_XFER, IFS_SPOLL, IFS_PPOLL: begin
                nxt_talk = 1'b1;
            end
            default: begin
                nxt_talk = 1'b0;
            end
        endcase
        case (ctl_e'(ctl_v))
            CTL_IDLE, CTL_ADDRESSED: nxt_acf = 1'b1;
            default:                 nxt_acf = 1'b0;
        endcase
    end

    // Steer with the values the pins will carry, so direction and enable
    // change on the same edge and no channel is briefly driven twice
    assign sif.steer  = nxt_acf;
    assign sif.talk   = nxt_talk;
    assign sif.sysctl = nxt_sysctl;
    assign sif.atn    = atn_lvl;

    always_comb begin
        nxt_state       = state_ff;
        nxt_state.sync1 = line_in;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.rd_data = '0;
        nxt_state.talk   = nxt_talk;
        nxt_state.acf    = nxt_acf;
        nxt_state.sysctl = nxt_sysctl;

        if (wr_stb) begin
            case (addr)
                ADDR_MODE: begin
                    nxt_state.ifs     = wr_data[MODE_IFS_LSB +: MODE_IFS_W];
                    nxt_state.ctl     = wr_data[MODE_CTL_LSB +: MODE_CTL_W];
                    nxt_state.pu_mode = wr_data[MODE_PU_LSB +: MODE_PU_W];
                end
                ADDR_DRIVE: begin
                    nxt_state.line_val[CH_ATN] = wr_data[DRV_ATN_BIT];
                    nxt_state.line_val[CH_EOI] = wr_data[DRV_EOI_BIT];
                    nxt_state.line_val[CH_SRQ] = wr_data[DRV_SRQ_BIT];
                end
                ADDR_CMD: begin
                    // Only a system controller may own REN and IFC
                    if (wr_data[CMD_REN_GO]) begin
                        if (state_ff.sysctl) begin
                            nxt_state.line_val[CH_REN] =
                                wr_data[CMD_REN_VAL];
                        end else begin
                            nxt_state.refused = 1'b1;
                        end
                    end
                    if (wr_data[CMD_IFC_GO]) begin
                        if (state_ff.sysctl) begin
                            nxt_state.line_val[CH_IFC] =
                                wr_data[CMD_IFC_VAL];
                        end else begin
                            nxt_state.refused = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        if (rd_stb) begin
            case (addr)
                ADDR_MODE: begin
                    nxt_state.rd_data[MODE_IFS_LSB +: MODE_IFS_W] =
                        state_ff.ifs;
                    nxt_state.rd_data[MODE_CTL_LSB +: MODE_CTL_W] =
                        state_ff.ctl;
                    nxt_state.rd_data[MODE_SYS_BIT] = state_ff.sysctl;
                    nxt_state.rd_data[MODE_PU_LSB +: MODE_PU_W] =
                        state_ff.pu_mode;
                end
                ADDR_DRIVE: begin
                    nxt_state.rd_data[DRV_ATN_BIT] =
                        state_ff.line_val[CH_ATN];
                    nxt_state.rd_data[DRV_EOI_BIT] =
                        state_ff.line_val[CH_EOI];
                    nxt_state.rd_data[DRV_SRQ_BIT] =
                        state_ff.line_val[CH_SRQ];
                end
                ADDR_STATUS: begin
                    nxt_state.rd_data[ST_LINES_LSB +: NUM_CH] =
                        state_ff.sync2;
                    nxt_state.rd_data[ST_TALK_BIT] = state_ff.talk;
                    nxt_state.rd_data[ST_ACF_BIT] = state_ff.acf;
                    nxt_state.rd_data[ST_PU_BIT]  = state_ff.pus;
                    nxt_state.rd_data[ST_REF_BIT] = state_ff.refused;
                    // Clear on read, unless a refusal lands in this cycle
                    if (!(wr_stb && addr == ADDR_CMD &&
                          (wr_data[CMD_REN_GO] || wr_data[CMD_IFC_GO]) &&
                          !state_ff.sysctl)) begin
                        nxt_state.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Outside PU_TOTEM, open collector whenever a parallel poll can be under way
        case (pu_e'(nxt_state.pu_mode))
            PU_OPEN:  nxt_state.pus = 1'b0;
            PU_TOTEM: nxt_state.pus = 1'b1;
            default: begin
                nxt_state.pus = ~((~atn_lvl & ~eoi_lvl) |
                    (ifs_e'(nxt_state.ifs) == IFS_PPOLL));
            end
        endcase

        // Host lets go of a channel the transceiver is driving back
        nxt_state.line_oe_n = ~sif.tx;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rd_data           = state_ff.rd_data;
    assign talk_enable       = state_ff.talk;
    assign active_ctl_flag   = state_ff.acf;
    assign system_ctl_select = state_ff.sysctl;
    assign pull_up_select    = state_ff.pus;
    assign line_out          = state_ff.line_val;
    assign line_oe_n         = state_ff.line_oe_n;

endmodule : gpib_host

// ==== verification/gpib_host_asserts.sv ====
// Concurrent checks on the ports of the GPIB steering host
`timescale 1ns/1ps
module gpib_host_asserts
    import gpib_host_pkg::*;
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic              wr_stb,
    input wire logic              rd_stb,
    input wire logic [DATA_W-1:0] rd_data,
    // Transceiver pins and lines
    input wire logic              talk_enable,
    input wire logic              active_ctl_flag,
    input wire logic              system_ctl_select,
    input wire logic              pull_up_select,
    input wire logic [NUM_CH-1:0] line_in,
    input wire logic [NUM_CH-1:0] line_out,
    input wire logic [NUM_CH-1:0] line_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic       live_ff;
    logic [7:0] mode_ff;
    logic [3:0] cmd_ff;
    wire        mode_wr = wr_stb && addr == ADDR_MODE;
    wire        cmd_wr  = wr_stb && addr == ADDR_CMD;
    // Directions are only settled one edge after reset release
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            live_ff <= 1'b0;
        end else begin
            live_ff <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (mode_wr) begin
            mode_ff <= wr_data[7:0];
        end
        if (cmd_wr) begin
            cmd_ff <= wr_data[3:0];
        end
    end
    a_atn_srq_dir:
    assert property (live_ff |-> line_oe_n[CH_ATN] == active_ctl_flag
        && line_oe_n[CH_SRQ] == !active_ctl_flag) else $error("ATN/SRQ dir");
    a_ren_ifc_dir:
    assert property (live_ff |-> line_oe_n[CH_REN] == !system_ctl_select
        && line_oe_n[CH_IFC] == !system_ctl_select) else $error("REN/IFC dir");
    a_eoi_differ:
    assert property (live_ff && active_ctl_flag != talk_enable
        |-> line_oe_n[CH_EOI] == !talk_enable) else $error("EOI dir differ");
    a_eoi_equal:
    assert property (live_ff && !active_ctl_flag && !talk_enable
        |-> line_oe_n[CH_EOI] == line_out[CH_ATN]) else $error("EOI dir equal");
    a_talk_state:
    assert property (mode_wr |=> talk_enable == (mode_ff[2:0] inside
        {[3'd1:3'd4]})) else $error("talk enable wrong");
    a_ctl_flag:
    assert property (mode_wr |=> active_ctl_flag == (mode_ff[4:3] < 2'd2))
        else $error("active controller flag wrong");
    a_pull_open:
    assert property (mode_wr && wr_data[7:6] == 2'd1 |=> !pull_up_select)
        else $error("open collector not chosen");
    a_cmd_refused:
    assert property (cmd_wr && !system_ctl_select && (wr_data[CMD_REN_GO]
        || wr_data[CMD_IFC_GO]) |=> $stable(line_out)) else $error("refusal");
    a_cmd_taken:
    assert property (cmd_wr && wr_data[CMD_REN_GO] && system_ctl_select
        |=> line_out[CH_REN] == cmd_ff[CMD_REN_VAL]) else $error("REN level");
    a_ifc_taken:
    assert property (cmd_wr && wr_data[CMD_IFC_GO] && system_ctl_select
        |=> line_out[CH_IFC] == cmd_ff[CMD_IFC_VAL]) else $error("IFC level");
endmodule : gpib_host_asserts

bind gpib_host gpib_host_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .talk_enable(talk_enable),
    .active_ctl_flag(active_ctl_flag), .system_ctl_select(system_ctl_select),
    .pull_up_select(pull_up_select), .line_in(line_in),
    .line_out(line_out), .line_oe_n(line_oe_n));

// ==== verification/xcvr_model.sv ====
// Management-channel transceiver with the instrument bus behind it
`timescale 1ns/1ps
module xcvr_model (
    // Clock and steering pins
    input  wire logic       clk_sys,
    input  wire logic       steer,
    input  wire logic       talk,
    input  wire logic       sysctl,
    // Terminal side
    input  wire logic [4:0] host_out,
    input  wire logic [4:0] host_oe_n,
    output logic      [4:0] term,
    // Bus side, other devices pull low
    input  wire logic [4:0] bus_other,
    output logic      [4:0] bus,
    output logic            clash
);
    logic [4:0] tx;
    logic [4:0] src;
    logic       atn_lv;
    logic       tog_ff = 1'b0;
    // Undriven terminal lines wander so a stale value never looks valid
    always @(posedge clk_sys) tog_ff <= ~tog_ff;
    always_comb begin
        tx = {sysctl, sysctl, steer, 1'b0, ~steer};
        src = (~host_oe_n & host_out) | (host_oe_n & {5{tog_ff}});
        atn_lv = bus_other[0] & (~tx[0] | src[0]);
        tx[1] = (steer == talk) ? (atn_lv ? talk : ~steer) : talk;
        bus = bus_other & (~tx | src);
        term = (tx & src) | (~tx & bus);
        clash = |(~tx & ~host_oe_n);
    end
endmodule : xcvr_model

// ==== verification/gpib_host_test.sv ====
// Self-checking bench of the GPIB steering host
`timescale 1ns/1ps
module gpib_host_test;
    import gpib_host_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst_n   = 1'b0;
    logic [ADDR_W-1:0] addr    = '0;
    logic [DATA_W-1:0] wr_data = '0;
    logic              wr_stb  = 1'b0;
    logic              rd_stb  = 1'b0;
    logic [DATA_W-1:0] rd_data;
    logic              talk_enable, active_ctl_flag;
    logic              system_ctl_select, pull_up_select, clash;
    logic [4:0]        line_in, line_out, line_oe_n, bus;
    logic [4:0]        b_oth   = 5'h1F;
    int                error_cnt = 0;
    int                n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    gpib_host i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rd_data(rd_data), .talk_enable(talk_enable),
        .active_ctl_flag(active_ctl_flag),
        .system_ctl_select(system_ctl_select),
        .pull_up_select(pull_up_select), .line_in(line_in),
        .line_out(line_out), .line_oe_n(line_oe_n));
    xcvr_model i_xcvr (.clk_sys(clk_sys), .steer(active_ctl_flag),
        .talk(talk_enable), .sysctl(system_ctl_select), .host_out(line_out),
        .host_oe_n(line_oe_n), .term(line_in), .bus_other(b_oth),
        .bus(bus), .clash(clash));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk_sys);
        addr <= a; wr_data <= d; wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        @(negedge clk_sys);
    endtask : wr
    task automatic rd(logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        addr <= a; rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(negedge clk_sys);
        v = rd_data;
    endtask : rd
    task automatic t_regs;
        logic [31:0] v;
        chk("talk_enable", 0, talk_enable);
        chk("ctl_flag", 1, active_ctl_flag);
        chk("sys_ctl", 0, system_ctl_select);
        chk("pull_up", 1, pull_up_select);
        wr(4'h1, 32'hFF);  // Unmapped write must be ignored
        rd(4'h1, v); chk("unmapped", 0, v);
        rd(ADDR_CMD, v); chk("cmd_read", 0, v);
        wr(ADDR_MODE, 32'h2A); rd(ADDR_MODE, v); chk("mode", 32'h2A, v);
        $display("test regs done");
    endtask : t_regs
    task automatic t_modes;
        for (int k = 0; k < 32; k++) begin
            wr(ADDR_MODE, 32'(k));
            chk("talk_enable", k[2:0] inside {[1:4]}, talk_enable);
            chk("ctl_flag", k[4:3] < 2, active_ctl_flag);
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_eoi;
        logic steer, talk, at, ex;
        for (int k = 0; k < 8; k++) begin
            {steer, talk, at} = 3'(k);
            wr(ADDR_MODE, {27'h0, steer ? 2'd0 : 2'd2, 2'd0, talk});
            wr(ADDR_DRIVE, {29'h0, 2'b11, at});
            @(posedge clk_sys) b_oth <= {4'hF, at};
            repeat (4) @(posedge clk_sys);
            @(negedge clk_sys);
            ex = (steer == talk) ? (at ? talk : ~steer) : talk;
            chk("eoi_dir", !ex, line_oe_n[CH_EOI]);
            chk("atn_dir", steer, line_oe_n[CH_ATN]);
            chk("srq_dir", !steer, line_oe_n[CH_SRQ]);
        end
        $display("test eoi done");
    endtask : t_eoi
    task automatic t_pass;
        logic [31:0] v;
        wr(ADDR_MODE, 32'h10);
        wr(ADDR_DRIVE, 32'h6);
        @(posedge clk_sys) b_oth <= 5'h1B;
        repeat (4) @(posedge clk_sys);
        rd(ADDR_STATUS, v); chk("status", 32'h9A, v);
        chk("bus_atn_eoi", 2'b10, bus[1:0]);
        $display("test pass done");
    endtask : t_pass
    task automatic t_sc;
        logic [31:0] v;
        @(posedge clk_sys) b_oth <= 5'h1F;
        wr(ADDR_MODE, 32'h0); wr(ADDR_CMD, 32'h5);
        chk("ren_ifc_kept", 2'b11, line_out[4:3]);
        rd(ADDR_STATUS, v); chk("refused", 1, v[ST_REF_BIT]);
        wr(ADDR_MODE, 32'h20); wr(ADDR_CMD, 32'h5);
        chk("ren_ifc_oe", 2'b00, line_oe_n[4:3]);
        chk("ren_ifc_bus", 2'b00, bus[4:3]);
        wr(ADDR_CMD, 32'hF); chk("ren_ifc_hi", 2'b11, bus[4:3]);
        $display("test sc done");
    endtask : t_sc
    task automatic t_pull;
        logic [31:0] pm[4] = '{32'h40, 32'h84, 32'h04, 32'h00};
        logic [3:0]  pe = 4'b1010;
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_MODE, pm[k]);
            chk("pull_up", pe[k], pull_up_select);
        end
        chk("clash", 0, clash);
        $display("test pull done");
    endtask : t_pull
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        t_regs(); t_modes(); t_eoi(); t_pass(); t_sc(); t_pull();
        final_report();
    end
    // All tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        final_report();
    end
endmodule : gpib_host_test
